//--- core/iepb_map.svh
`ifndef IEPB_MAP_SVH
`define IEPB_MAP_SVH

// byte offsets, bits [7:5] pick the region, bits [4:2] the word
`define IEPB_REGION_EN    3'h0
`define IEPB_REGION_FLAG  3'h1
`define IEPB_REGION_PRI   3'h2
`define IEPB_REGION_MISC  3'h3
`define IEPB_EN_BASE      8'h00
`define IEPB_FLAG_BASE    8'h20
`define IEPB_PRI_BASE     8'h40
`define IEPB_IRQ_STAT     8'h60
`define IEPB_IRQ_MASK     8'h64
`define IEPB_WIN_STAT     8'h68

// implemented enable / flag bits per word; word 2 has none
`define IEPB_EN_MASK0     16'h3fef
`define IEPB_EN_MASK1     16'h20db
`define IEPB_EN_MASK2     16'h0000
`define IEPB_EN_MASK3     16'h8600
`define IEPB_EN_MASK4     16'h0602
`define IEPB_EN_RST       16'h0000

// implemented priority bits and their reset values
`define IEPB_PRI_MASK0    16'h7777
`define IEPB_PRI_MASK1    16'h7770
`define IEPB_PRI_MASK2    16'h7777
`define IEPB_PRI_RST0     16'h4444
`define IEPB_PRI_RST1     16'h4440
`define IEPB_PRI_RST2     16'h4444

// sources 0..11 own a priority field; the rest use a fixed level
`define IEPB_NUM_PRI_SRC  7'd12
`define IEPB_FIXED_LEVEL  3'h4

// irq status / mask bit positions
`define IEPB_EV_RAISE     0
`define IEPB_EV_PREEMPT   1
`define IEPB_EV_BLOCKED   2
`define IEPB_EV_WIDTH     3

// winner status fields
`define IEPB_WIN_SRC_LSB  0
`define IEPB_WIN_LVL_LSB  8
`define IEPB_WIN_REQ_BIT  11

`endif

//--- core/iepb_pkg.sv
package iepb_pkg;
  typedef logic [2:0]  iepb_level_t;
  typedef logic [15:0] iepb_word_t;
  typedef logic [6:0]  iepb_src_t;
  typedef enum logic [1:0] {
    IEPB_HTRANS_IDLE   = 2'b00,
    IEPB_HTRANS_BUSY   = 2'b01,
    IEPB_HTRANS_NONSEQ = 2'b10,
    IEPB_HTRANS_SEQ    = 2'b11
  } iepb_htrans_t;
endpackage : iepb_pkg

//--- core/iepb_top.sv
// The AHB-Lite slave port and the register addresses were left to the implementer.
`include "iepb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iepb_top
  import iepb_pkg::*;
#(
  parameter int NREG = 5,
  parameter int NPRI = 3
) (
  input  wire logic              clk_sys_in,
  input  wire logic              srst_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire logic [NREG*16-1:0] src_req_in,
  output logic                   cpu_req_out,
  output logic      [2:0]        cpu_level_out,
  output logic      [6:0]        cpu_src_out,
  output logic                   irq_out
);

  // one request bit per enable position, implemented or not
  localparam int NSRC = NREG * 16;

  function automatic iepb_word_t en_mask(input int k);
    case (k)
      0:       en_mask = `IEPB_EN_MASK0;
      1:       en_mask = `IEPB_EN_MASK1;
      3:       en_mask = `IEPB_EN_MASK3;
      4:       en_mask = `IEPB_EN_MASK4;
      default: en_mask = `IEPB_EN_MASK2;
    endcase
  endfunction : en_mask

  function automatic iepb_word_t pri_mask(input int k);
    case (k)
      0:       pri_mask = `IEPB_PRI_MASK0;
      1:       pri_mask = `IEPB_PRI_MASK1;
      default: pri_mask = `IEPB_PRI_MASK2;
    endcase
  endfunction : pri_mask

  function automatic iepb_word_t pri_rst(input int k);
    case (k)
      0:       pri_rst = `IEPB_PRI_RST0;
      1:       pri_rst = `IEPB_PRI_RST1;
      default: pri_rst = `IEPB_PRI_RST2;
    endcase
  endfunction : pri_rst

  logic [NREG-1:0][15:0] en_ff;
  logic [NREG-1:0][15:0] flag_ff;
  logic [NPRI-1:0][15:0] pri_ff;
  logic [NSRC-1:0]       impl;
  logic [NSRC-1:0]       en_flat;
  logic [NSRC-1:0]       flag_flat;

  assign en_flat   = en_ff;
  assign flag_flat = flag_ff;

  // implemented-bit map, used by the blocked check; the flag gating calls en_mask itself
  for (genvar g = 0; g < NREG; g++) begin : g_impl
    assign impl[g*16 +: 16] = en_mask(g);
  end

  // sources 0..11 map four to a priority word, field j at bits 4j+2..4j
  function automatic iepb_level_t src_level(input int s, input logic [NPRI-1:0][15:0] p);
    iepb_level_t lv;
    lv = `IEPB_FIXED_LEVEL;
    if (s < int'(`IEPB_NUM_PRI_SRC)) begin
      lv = p[s / 4][(s % 4) * 4 +: 3];
    end
    return lv;
  endfunction : src_level

  // bus address / data phase tracking
  logic       accept;
  logic       wr_pend_ff;
  logic       rd_pend_ff;
  logic [7:0] addr_ff;
  logic       hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        hresp_ff;

  // a transfer is taken only while the bus is ready
  assign accept = hsel_in && htrans_in[1] && hready_in;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= accept && hwrite_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_pend_ff <= 1'b0;
    end else begin
      rd_pend_ff <= accept && !hwrite_in;
    end
  end

  // address kept for the data phase, when hwdata finally arrives
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      addr_ff <= 8'h00;
    end else if (accept) begin
      addr_ff <= haddr_in[7:0];
    end
  end

  // reads take one wait state because the read data is registered into hrdata in the data phase
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= !(accept && !hwrite_in);
    end
  end

  // every response is okay; a flop so all outputs come from registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  logic [2:0] a_region;
  logic [2:0] a_word;
  assign a_region = addr_ff[7:5];
  assign a_word   = addr_ff[4:2];

  // write data phase hitting word k of one region
  function automatic logic wr_hit(input logic [2:0] region, input int k);
    return wr_pend_ff && a_region == region && a_word == 3'(k);
  endfunction : wr_hit

  // register writes
  // enables restart closed; software opens the sources it serves
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      en_ff <= '0;
    end else begin
      for (int k = 0; k < NREG; k++) begin
        if (wr_hit(`IEPB_REGION_EN, k)) begin
          en_ff[k] <= hwdata_in[15:0] & en_mask(k);
        end
      end
    end
  end

  // fields restart at level four, except source 4's unimplemented field, which stays zero and disables it
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int k = 0; k < NPRI; k++) begin
        pri_ff[k] <= pri_rst(k);
      end
    end else begin
      for (int k = 0; k < NPRI; k++) begin
        if (wr_hit(`IEPB_REGION_PRI, k)) begin
          pri_ff[k] <= hwdata_in[15:0] & pri_mask(k);
        end
      end
    end
  end

  // a source event in the write cycle wins over a software clear
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      flag_ff <= '0;
    end else begin
      for (int k = 0; k < NREG; k++) begin
        if (wr_hit(`IEPB_REGION_FLAG, k)) begin
          flag_ff[k] <= (hwdata_in[15:0] | src_req_in[k*16 +: 16]) & en_mask(k);
        end else begin
          flag_ff[k] <= (flag_ff[k] | src_req_in[k*16 +: 16]) & en_mask(k);
        end
      end
    end
  end

  // arbitration: strict compare keeps the first (lowest) source on a tie
  iepb_level_t best_lvl;
  iepb_src_t   best_src;
  logic        blocked;

  always_comb begin
    iepb_level_t lv;
    lv       = '0;
    best_lvl = '0;
    best_src = '0;
    for (int i = 0; i < NSRC; i++) begin
      lv = src_level(i, pri_ff);
      if (flag_flat[i] && en_flat[i] && lv != 3'h0 && lv > best_lvl) begin
        best_lvl = lv;
        best_src = 7'(i);
      end
    end
  end

  // request seen while its gate is shut, for the blocked status bit
  always_comb begin
    iepb_level_t lvb;
    lvb     = '0;
    blocked = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      lvb = src_level(i, pri_ff);
      if (impl[i] && src_req_in[i] && (!en_flat[i] || lvb == 3'h0)) begin
        blocked = 1'b1;
      end
    end
  end

  logic        cpu_req_ff;
  iepb_level_t cpu_level_ff;
  iepb_src_t   cpu_src_ff;
  logic        nxt_req;

  assign nxt_req = best_lvl != 3'h0;

  // registered winner: level and source reach the core in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cpu_req_ff <= 1'b0;
    end else begin
      cpu_req_ff <= nxt_req;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cpu_level_ff <= '0;
    end else begin
      cpu_level_ff <= best_lvl;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cpu_src_ff <= '0;
    end else begin
      cpu_src_ff <= best_src;
    end
  end

  // event status, cleared by reading it; a new event beats the clear
  logic [`IEPB_EV_WIDTH-1:0] irq_stat_ff;
  logic [`IEPB_EV_WIDTH-1:0] irq_mask_ff;
  logic [`IEPB_EV_WIDTH-1:0] events;
  logic                      irq_ff;
  logic                      stat_read;
  logic [`IEPB_EV_WIDTH-1:0] nxt_irq_stat;

  // raise and preempt are single-cycle strobes; blocked lasts as long as the shut-out request does; all set the sticky status
  always_comb begin
    events = '0;
    events[`IEPB_EV_RAISE]   = nxt_req && !cpu_req_ff;
    events[`IEPB_EV_PREEMPT] = nxt_req && cpu_req_ff && best_lvl > cpu_level_ff;
    events[`IEPB_EV_BLOCKED] = blocked;
  end

  assign stat_read    = rd_pend_ff && addr_ff == `IEPB_IRQ_STAT;
  assign nxt_irq_stat = (stat_read ? '0 : irq_stat_ff) | events;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // only masked-in status bits drive the interrupt line
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_mask_ff <= '0;
    end else if (wr_pend_ff && addr_ff == `IEPB_IRQ_MASK) begin
      irq_mask_ff <= hwdata_in[`IEPB_EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // read mux; unmapped offsets read zero
  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    unique case (a_region)
      `IEPB_REGION_EN: begin
        if (int'(a_word) < NREG) begin
          rd_val[15:0] = en_ff[a_word];
        end
      end
      `IEPB_REGION_FLAG: begin
        if (int'(a_word) < NREG) begin
          rd_val[15:0] = flag_ff[a_word];
        end
      end
      `IEPB_REGION_PRI: begin
        if (int'(a_word) < NPRI) begin
          rd_val[15:0] = pri_ff[a_word];
        end
      end
      `IEPB_REGION_MISC: begin
        if (addr_ff == `IEPB_IRQ_STAT) begin
          rd_val[`IEPB_EV_WIDTH-1:0] = irq_stat_ff;
        end else if (addr_ff == `IEPB_IRQ_MASK) begin
          rd_val[`IEPB_EV_WIDTH-1:0] = irq_mask_ff;
        end else if (addr_ff == `IEPB_WIN_STAT) begin
          rd_val[`IEPB_WIN_SRC_LSB +: 7] = cpu_src_ff;
          rd_val[`IEPB_WIN_LVL_LSB +: 3] = cpu_level_ff;
          rd_val[`IEPB_WIN_REQ_BIT]      = cpu_req_ff;
        end
      end
      default: rd_val = '0;
    endcase
  end

  // read data holds until the next read completes
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hrdata_ff <= '0;
    end else if (rd_pend_ff) begin
      hrdata_ff <= rd_val;
    end
  end

  assign hrdata_out    = hrdata_ff;
  assign hreadyout_out = hreadyout_ff;
  assign hresp_out     = hresp_ff;
  assign cpu_req_out   = cpu_req_ff;
  assign cpu_level_out = cpu_level_ff;
  assign cpu_src_out   = cpu_src_ff;
  assign irq_out       = irq_ff;

endmodule : iepb_top

`default_nettype wire

//--- tb/iepb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iepb_asserts #(
  parameter int NREG = 5
) (
  input wire logic       clk_sys_in,
  input wire logic       srst_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hwrite_in,
  input wire logic       hready_in,
  input wire logic       hreadyout_out,
  input wire logic       hresp_out,
  input wire logic       cpu_req_out,
  input wire logic [2:0] cpu_level_out,
  input wire logic [6:0] cpu_src_out,
  input wire logic       irq_out
);
  logic take;
  assign take = hsel_in && htrans_in[1] && hready_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // flags only clear by software, so a drop needs a bus transfer shortly before
  property p_req_fall;
    $fell(cpu_req_out) |-> $past(take, 2) || $past(take, 3) || $past(take, 4);
  endproperty
  a_req_fall: assert property (p_req_fall) else $error("request dropped");
  property p_irq_fall;
    $fell(irq_out) |-> $past(take, 2) || $past(take, 3) || $past(take, 4);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  property p_lvl_nz;
    cpu_req_out |-> cpu_level_out != 3'h0;
  endproperty
  a_lvl_nz: assert property (p_lvl_nz) else $error("level zero requests");
  property p_idle;
    !cpu_req_out |-> cpu_level_out == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("level without request");
  property p_src;
    cpu_req_out |-> cpu_src_out < NREG * 16;
  endproperty
  a_src: assert property (p_src) else $error("source out of range");
  property p_rd;
    take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr;
    take && hwrite_in |=> hreadyout_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_resp;
    hresp_out == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_rst;
    disable iff (1'b0) srst_in |=> !cpu_req_out && !irq_out && hreadyout_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : iepb_asserts
bind iepb_top iepb_asserts #(.NREG(NREG)) u_chk (.clk_sys_in, .srst_in, .hsel_in,
  .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hresp_out, .cpu_req_out,
  .cpu_level_out, .cpu_src_out, .irq_out);
`default_nettype wire

//--- tb/iepb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module iepb_src_model #(
  parameter int NREG = 5
) (
  input wire logic            clk_sys_in,
  output logic [NREG*16-1:0]  src_req_out
);
  initial src_req_out = '0;
  // one-cycle event pulses, as peripherals raise them
  task automatic fire(input logic [NREG*16-1:0] bits);
    src_req_out <= bits;
    @(posedge clk_sys_in);
    src_req_out <= '0;
  endtask : fire
endmodule : iepb_src_model
`default_nettype wire

//--- tb/iepb_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module iepb_top_test;
  import iepb_pkg::*;
  logic        clk_sys_in;
  logic        srst_in;
  logic        hsel;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [79:0] src_req;
  logic        cpu_req;
  logic [2:0]  cpu_level;
  logic [6:0]  cpu_src;
  logic        irq;
  logic [31:0] rdat;
  int          err_total;
  int          cmp_count;
  logic [15:0] en_msk [5] = '{16'h3fef, 16'h20db, 16'h0000, 16'h8600, 16'h0602};
  logic [15:0] pri_msk [3] = '{16'h7777, 16'h7770, 16'h7777};
  iepb_top u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .src_req_in(src_req), .cpu_req_out(cpu_req),
    .cpu_level_out(cpu_level), .cpu_src_out(cpu_src), .irq_out(irq));
  iepb_src_model u_src (.clk_sys_in(clk_sys_in), .src_req_out(src_req));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= IEPB_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans <= IEPB_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rdat = hrdata;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk
  // fixed wait: flag lands one edge after the pulse, outputs one edge later
  task automatic cpu_chk(input logic [10:0] exp);
    repeat (3) @(posedge clk_sys_in);
    chk({21'h0, cpu_req, cpu_level, cpu_src}, {21'h0, exp});
  endtask : cpu_chk
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  initial begin
    err_total = 0;
    cmp_count = 0;
    srst_in = 1'b1;
    hsel = 1'b0;
    htrans = IEPB_HTRANS_IDLE;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    for (int k = 0; k < 5; k++) begin
      rd_chk(8'(4 * k), 32'h0);
      xfer(1'b1, 8'(4 * k), 32'hffff_ffff);
      rd_chk(8'(4 * k), {16'h0, en_msk[k]});
    end
    for (int k = 0; k < 3; k++) begin
      rd_chk(8'(8'h40 + 4 * k), {16'h0, pri_msk[k] & 16'h4444});
      xfer(1'b1, 8'(8'h40 + 4 * k), 32'hffff_ffff);
      rd_chk(8'(8'h40 + 4 * k), {16'h0, pri_msk[k]});
    end
    xfer(1'b1, 8'h7c, 32'hffff_ffff);
    rd_chk(8'h7c, 32'h0);
    xfer(1'b1, 8'h40, 32'h0070);
    u_src.fire(80'h1);
    cpu_chk(11'h0);
    u_src.fire(80'h2);
    cpu_chk({1'b1, 3'h7, 7'h1});
    xfer(1'b1, 8'h20, 32'h0);
    cpu_chk(11'h0);
    xfer(1'b1, 8'h40, 32'h0011);
    u_src.fire(80'h3);
    cpu_chk({1'b1, 3'h1, 7'h0});
    xfer(1'b1, 8'h40, 32'h0053);
    cpu_chk({1'b1, 3'h5, 7'h1});
    xfer(1'b1, 8'h20, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b0, 8'h60, 32'h0);
    u_src.fire(80'h1);
    cpu_chk(11'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h64, 32'h1);
    xfer(1'b1, 8'h00, 32'h1);
    cpu_chk({1'b1, 3'h3, 7'h0});
    chk({31'h0, irq}, 32'h1);
    rd_chk(8'h20, 32'h1);
    rd_chk(8'h60, 32'h5);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h68, 32'h0000_0b00);
    rd_chk(8'h64, 32'h1);
    u_src.fire(80'h0000_8000_0000_0005_0000);
    cpu_chk({1'b1, 3'h4, 7'h10});
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h24, 32'h1);
    rd_chk(8'h2c, 32'h8000);
    rd_chk(8'h60, 32'h2);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    cpu_chk(11'h0);
    rd_chk(8'h40, 32'h4444);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h04, 32'h0);
    end_sim();
  end
endmodule : iepb_top_test
`default_nettype wire
